/* File: src/pfm_pkg.sv */
`default_nettype none
package pfm_pkg;
   // ==========================================================
   // Thresholds and timing
   // ==========================================================
   localparam int          CLK_KHZ       = 50000;
   localparam int          RESTART_MS    = 130;
   localparam int          RESTART_CYC   = RESTART_MS * CLK_KHZ;
   localparam logic [7:0]  OT_WARN_C     = 8'h78;   // 120 C
   localparam logic [7:0]  OT_WARN_CLR_C = 8'h75;   // 117 C
   localparam logic [7:0]  OT_FAULT_C    = 8'h82;   // 130 C
   localparam logic [7:0]  PG_HI_PCT     = 8'h6E;   // 110 %
   localparam logic [7:0]  PG_LO_PCT_A   = 8'h5A;   // 90 %
   localparam logic [7:0]  PG_LO_PCT_B   = 8'h5F;   // 95 %
   localparam logic [7:0]  OV_MIN_PCT    = 8'h6E;   // 110 %
   localparam logic [7:0]  OV_MAX_PCT    = 8'h82;   // 130 %
   localparam logic [13:0] OV_FLOOR_MV   = 14'h03E8; // 1.0 V
   localparam logic [13:0] TRK_LIM_MV    = 14'h00FA; // 250 mV
   localparam logic [7:0]  PCT_FULL      = 8'h64;   // 100 %

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      ST_OFF  = 3'b000,
      ST_RAMP = 3'b001,
      ST_RUN  = 3'b010,
      ST_DOWN = 3'b011,
      ST_FAST = 3'b100,
      ST_WAIT = 3'b101
   } pfm_state_t;

   // Status bits, active low: 1 means condition absent
   typedef struct packed {
      logic temp_warning_flag;
      logic power_good_flag;
      logic overcurrent_flag;
      logic undervoltage_flag;
      logic overtemp_flag;
      logic tracking_flag;
      logic overvoltage_flag;
   } pfm_status_t;

   localparam pfm_status_t STATUS_RST = 7'h7F;

   typedef struct packed {
      logic trk_dis;    // Tracking protection disable
      logic latch_oc;
      logic latch_uv;
      logic latch_ot;
      logic latch_tr;
      logic latch_ov;
   } pfm_cfg_one_t;

   typedef struct packed {
      logic report_en;  // Warning reporting to manager
      logic prop_en;    // In-group propagation
   } pfm_cfg_three_t;

   typedef struct packed {
      logic       pg_lo_95;  // 1: 95 %, 0: 90 %
      logic [7:0] ov_pct;
      logic [7:0] uv_pct;
   } pfm_cfg_two_t;
endpackage : pfm_pkg
`default_nettype wire

/* File: src/pfm_protect.sv */
// Operation
// - Temperature above 120 C raises warning, clears status bit, reports.
// - Warning withdrawn, bit restored once temperature drops below 117 C.
// - Warnings reach the manager only while reporting enable is set.
// - Power-good window is 110 % high and 90 or 95 % low.
// - Power-good checked only in steady state; pin low during transitions.
// - Power-good warning pulls pin low, clears bit; released on return.
// - An outside pull-down of the power-good line counts as warning.
// - Warnings never switch the converter off.
// - Limiting above prebias and low output: overcurrent fault, fast off.
// - Fast turn-off opens both power switches at once, no ramp; after overvoltage the low side is closed.
// - Overcurrent temperature compensation follows setpoint register bit.
// - Steady state undervoltage without overcurrent: fault, regular off.
// - Temperature above 130 C at any time: overtemp fault, regular off.
// - Non-latching overtemp restarts once temperature falls below 120 C.
// - During ramp-up, tracking error above 250 mV: fault, fast off.
// - Tracking protection disabled by its configuration bit.
// - Above prebias, overvoltage: error, high side off, low side on.
// - Overvoltage threshold 110 to 130 % of setpoint, never below 1.0 V.
// - A group holds 1 to 32 converters on one open-drain line.
// - With propagation enabled, a faulty converter pulls group line low.
// - A low group line turns this converter off without own fault.
// - Non-latching protection retries every 130 ms until the cause clears.
// - Latching stays off; restart after 130 ms needs clear or reset.
// - Propagated fault gives regular off, propagated error gives fast off.
`timescale 1ns/10ps
`default_nettype none
module pfm_protect #(
   parameter int RESTART_CYCLES = pfm_pkg::RESTART_CYC,
   parameter int MV_W           = 14
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire logic                     on_cmd,
   input  wire logic                     ramp_done,
   input  wire logic                     above_prebias,
   input  wire logic                     ilim_active,
   input  wire logic [7:0]               temp_c,
   input  wire logic [MV_W-1:0]          vout_mv,
   input  wire logic [MV_W-1:0]          vset_mv,
   input  wire logic [MV_W-1:0]          vramp_mv,
   input  wire pfm_pkg::pfm_cfg_one_t    protection_config_one,
   input  wire pfm_pkg::pfm_cfg_two_t    protection_config_two,
   input  wire pfm_pkg::pfm_cfg_three_t  protection_config_three,
   input  wire logic                     current_limit_setpoint_tc,
   input  wire logic                     status_clr,
   input  wire logic                     pg_in,
   input  wire logic                     grp_in,
   input  wire logic                     grp_fast,
   output logic                          pg_out,
   output logic                          pg_oe,
   output logic                          grp_out,
   output logic                          grp_oe,
   output pfm_pkg::pfm_status_t          protection_status_reg,
   output logic                          warn_report,
   output logic                          tcomp_en,
   output logic                          ramp_up,
   output logic                          ramp_down,
   output logic                          steady,
   output logic                          fast_off,
   output logic                          ls_on
);
   // ==========================================================
   // Elaboration checks
   // ==========================================================
   localparam int TW = 23;
   if (RESTART_CYCLES < 1 || RESTART_CYCLES >= (1 << TW))
      $error("RESTART_CYCLES out of range");
   if (MV_W < 11 || MV_W > 14)
      $error("MV_W must be 11 to 14");

   localparam logic [TW-1:0] RESTART_LAST = TW'(RESTART_CYCLES - 1);

   pfm_pkg::pfm_state_t  state_q;
   pfm_pkg::pfm_status_t protection_status_reg_q;
   logic [TW-1:0]        timer_q;
   logic                 latch_q;
   logic                 ot_cause_q;
   logic                 ov_cause_q;
   logic                 grp_cause_q;
   logic                 reset_seen_q;
   logic                 temp_warn_q;
   logic                 fault_q;

   // ==========================================================
   // Thresholds from setpoint percentages
   // ==========================================================
   logic [7:0]  ov_pct;
   logic [7:0]  pg_lo_pct;
   logic [21:0] pg_hi_thr;
   logic [21:0] pg_lo_thr;
   logic [21:0] uv_thr;
   logic [21:0] ov_raw;
   logic [21:0] ov_thr;
   logic [21:0] vout_w;
   logic [14:0] trk_diff;

   always_comb
   begin
      ov_pct = protection_config_two.ov_pct;
      if (ov_pct < pfm_pkg::OV_MIN_PCT)
         ov_pct = pfm_pkg::OV_MIN_PCT;
      if (ov_pct > pfm_pkg::OV_MAX_PCT)
         ov_pct = pfm_pkg::OV_MAX_PCT;
      pg_lo_pct = protection_config_two.pg_lo_95 ? pfm_pkg::PG_LO_PCT_B
                                                 : pfm_pkg::PG_LO_PCT_A;
      pg_hi_thr = 22'(vset_mv * pfm_pkg::PG_HI_PCT) / 22'(pfm_pkg::PCT_FULL);
      pg_lo_thr = 22'(vset_mv * pg_lo_pct) / 22'(pfm_pkg::PCT_FULL);
      uv_thr    = 22'(vset_mv * protection_config_two.uv_pct)
                  / 22'(pfm_pkg::PCT_FULL);
      ov_raw    = 22'(vset_mv * ov_pct) / 22'(pfm_pkg::PCT_FULL);
      ov_thr    = (ov_raw < 22'(pfm_pkg::OV_FLOOR_MV))
                  ? 22'(pfm_pkg::OV_FLOOR_MV) : ov_raw;
      vout_w    = 22'(vout_mv);
      trk_diff  = (vout_mv > vramp_mv) ? 15'(vout_mv - vramp_mv)
                                       : 15'(vramp_mv - vout_mv);
   end

   // ==========================================================
   // Event detection
   // ==========================================================
   logic below_uv;
   logic oc_ev;
   logic uv_ev;
   logic ot_ev;
   logic tr_ev;
   logic ov_ev;
   logic pg_bad;
   logic pg_ext;
   logic grp_low;
   logic fault_ev;
   logic hard_ev;
   logic soft_ev;
   logic cause_ok;

   always_comb
   begin
      below_uv = vout_w < uv_thr;
      // overcurrent shows as undervoltage while limiting
      oc_ev    = above_prebias && ilim_active && below_uv;
      // undervoltage only in steady state, not overcurrent
      uv_ev    = (state_q == pfm_pkg::ST_RUN) && below_uv && !oc_ev;
      ot_ev    = temp_c > pfm_pkg::OT_FAULT_C;
      tr_ev    = (state_q == pfm_pkg::ST_RAMP)
                 && !protection_config_one.trk_dis
                 && (trk_diff > 15'(pfm_pkg::TRK_LIM_MV));
      ov_ev    = above_prebias && (vout_w > ov_thr);
      pg_bad   = (vout_w > pg_hi_thr) || (vout_w < pg_lo_thr);
      // outside pull-down seen while we release the pin
      pg_ext   = !pg_in && !pg_oe;
      // low group line from a peer or the manager
      grp_low  = !grp_in && !grp_oe;
      fault_ev = oc_ev || uv_ev || ot_ev || tr_ev || ov_ev;
      // fast for own hard events and propagated errors
      hard_ev  = oc_ev || tr_ev || ov_ev || (grp_low && grp_fast);
      soft_ev  = uv_ev || ot_ev || grp_low;
      // overtemp cause clears below the warning level
      cause_ok = !(ot_cause_q && !(temp_c < pfm_pkg::OT_WARN_C))
                 && !(grp_cause_q && grp_low);
   end

   // ==========================================================
   // Converter state machine
   // ==========================================================
   logic active;
   assign active = (state_q == pfm_pkg::ST_RAMP)
                   || (state_q == pfm_pkg::ST_RUN);

   // only faults, errors, the group line and on command low leave a running state
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         state_q <= pfm_pkg::ST_OFF;
      else
      begin
         unique case (state_q)
            pfm_pkg::ST_OFF:
               if (on_cmd && !grp_low)
                  state_q <= pfm_pkg::ST_RAMP;
            pfm_pkg::ST_RAMP, pfm_pkg::ST_RUN:
               // hard events go straight to fast off
               if (hard_ev)
                  state_q <= pfm_pkg::ST_FAST;
               else if (soft_ev || !on_cmd)
                  state_q <= pfm_pkg::ST_DOWN;
               else if (state_q == pfm_pkg::ST_RAMP && ramp_done)
                  state_q <= pfm_pkg::ST_RUN;
            pfm_pkg::ST_DOWN:
               if (ov_ev)
                  state_q <= pfm_pkg::ST_FAST;
               else if (ramp_done)
                  state_q <= (fault_q) ? pfm_pkg::ST_WAIT : pfm_pkg::ST_OFF;
            pfm_pkg::ST_FAST:
               state_q <= pfm_pkg::ST_WAIT;
            pfm_pkg::ST_WAIT:
               // retry after the hiccup if cause is gone
               // latching also needs a clear or on cycle
               if (timer_q == RESTART_LAST && cause_ok
                   && (!latch_q || reset_seen_q))
                  state_q <= pfm_pkg::ST_OFF;
            default:
               state_q <= pfm_pkg::ST_OFF;
         endcase
      end
   end

   // Shutdown bookkeeping, fault_q marks a protective shutdown
   logic trip;
   assign trip = active && (hard_ev || soft_ev);

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         fault_q     <= 1'b0;
         latch_q     <= 1'b0;
         ot_cause_q  <= 1'b0;
         ov_cause_q  <= 1'b0;
         grp_cause_q <= 1'b0;
      end
      else if (trip || (state_q == pfm_pkg::ST_DOWN && ov_ev))
      begin
         fault_q     <= 1'b1;
         latch_q     <= (oc_ev && protection_config_one.latch_oc)
                     || (uv_ev && protection_config_one.latch_uv)
                     || (ot_ev && protection_config_one.latch_ot)
                     || (tr_ev && protection_config_one.latch_tr)
                     || (ov_ev && protection_config_one.latch_ov);
         ot_cause_q  <= ot_ev;
         ov_cause_q  <= ov_ev;
         grp_cause_q <= grp_low && !fault_ev;
      end
      else if (state_q == pfm_pkg::ST_OFF)
         fault_q <= 1'b0;
   end

   // Hiccup timer, counts from the output reaching zero
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         timer_q <= '0;
      else if (state_q != pfm_pkg::ST_WAIT)
         timer_q <= '0;
      else if (timer_q != RESTART_LAST)
         timer_q <= timer_q + 1'b1;
   end

   // status clear or on command low re-arms a latched part
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         reset_seen_q <= 1'b0;
      else if (state_q != pfm_pkg::ST_WAIT)
         reset_seen_q <= 1'b0;
      else if (status_clr || !on_cmd)
         reset_seen_q <= 1'b1;
   end

   // ==========================================================
   // Status bits, active low; a set beats a clear
   // ==========================================================
   // hysteresis on the warning
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         temp_warn_q <= 1'b0;
      else if (temp_c > pfm_pkg::OT_WARN_C)
         temp_warn_q <= 1'b1;
      else if (temp_c < pfm_pkg::OT_WARN_CLR_C)
         temp_warn_q <= 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         protection_status_reg_q <= pfm_pkg::STATUS_RST;
      else
      begin
         protection_status_reg_q.temp_warning_flag <= !temp_warn_q;
         // power-good bit follows the window in steady state
         protection_status_reg_q.power_good_flag <=
            !((state_q == pfm_pkg::ST_RUN) && (pg_bad || pg_ext));
         if (active && oc_ev)
            protection_status_reg_q.overcurrent_flag <= 1'b0;
         else if (status_clr)
            protection_status_reg_q.overcurrent_flag <= 1'b1;
         if (active && uv_ev)
            protection_status_reg_q.undervoltage_flag <= 1'b0;
         else if (status_clr)
            protection_status_reg_q.undervoltage_flag <= 1'b1;
         if (ot_ev)
            protection_status_reg_q.overtemp_flag <= 1'b0;
         else if (status_clr)
            protection_status_reg_q.overtemp_flag <= 1'b1;
         if (active && tr_ev)
            protection_status_reg_q.tracking_flag <= 1'b0;
         else if (status_clr)
            protection_status_reg_q.tracking_flag <= 1'b1;
         if (ov_ev)
            protection_status_reg_q.overvoltage_flag <= 1'b0;
         else if (status_clr)
            protection_status_reg_q.overvoltage_flag <= 1'b1;
      end
   end
   assign protection_status_reg = protection_status_reg_q;

   // ==========================================================
   // Pins and stage controls, all registered
   // ==========================================================
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pg_out      <= 1'b0;
         pg_oe       <= 1'b1;
         grp_out     <= 1'b0;
         grp_oe      <= 1'b0;
         warn_report <= 1'b0;
         tcomp_en    <= 1'b1;
         ramp_up     <= 1'b0;
         ramp_down   <= 1'b0;
         steady      <= 1'b0;
         fast_off    <= 1'b0;
         ls_on       <= 1'b0;
      end
      else
      begin
         // pin held low outside steady state
         pg_oe       <= (state_q != pfm_pkg::ST_RUN) || pg_bad;
         // propagation drives the group line low
         grp_oe      <= protection_config_three.prop_en && fault_q
                        && !grp_cause_q;
         warn_report <= protection_config_three.report_en
                        && (temp_warn_q
                            || !protection_status_reg_q.power_good_flag);
         // compensation enable passed to the current sense
         tcomp_en    <= current_limit_setpoint_tc;
         ramp_up     <= state_q == pfm_pkg::ST_RAMP;
         ramp_down   <= state_q == pfm_pkg::ST_DOWN;
         steady      <= state_q == pfm_pkg::ST_RUN;
         fast_off    <= (state_q == pfm_pkg::ST_FAST)
                        || (state_q == pfm_pkg::ST_WAIT);
         // low side closed for an overvoltage error
         ls_on       <= ov_cause_q && ((state_q == pfm_pkg::ST_FAST)
                        || (state_q == pfm_pkg::ST_WAIT));
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_hard_trip;
      active && hard_ev;
   endsequence

   a_fast_off_path: assert property (
      s_hard_trip |=> ##1 fast_off)
      else $error("Hard event did not give fast off");
   a_ov_low_side: assert property (
      active && ov_ev |=> ##1 ls_on && fast_off)
      else $error("Overvoltage did not close low side");
   a_uv_regular_off: assert property (
      state_q == pfm_pkg::ST_RUN && uv_ev && !hard_ev |=> ##1 ramp_down)
      else $error("Undervoltage did not ramp down");
   a_temp_warn_bit: assert property (
      temp_c > pfm_pkg::OT_WARN_C |=> ##1
      !protection_status_reg.temp_warning_flag)
      else $error("Temperature warning bit not cleared");
   a_pg_transition: assert property (
      $past(state_q) != pfm_pkg::ST_RUN |-> pg_oe)
      else $error("Power-good released outside steady state");
   a_report_gate: assert property (
      $past(!protection_config_three.report_en) |-> !warn_report)
      else $error("Warning reported while disabled");
   a_group_drive: assert property (
      grp_oe |-> $past(protection_config_three.prop_en) && !grp_out)
      else $error("Group line driven without propagation");
   a_hiccup_hold: assert property (
      state_q == pfm_pkg::ST_WAIT && timer_q != RESTART_LAST
      |=> state_q == pfm_pkg::ST_WAIT)
      else $error("Restart before hiccup expired");
   a_warn_no_off: assert property (
      state_q == pfm_pkg::ST_RUN && on_cmd && !hard_ev && !soft_ev
      |=> state_q == pfm_pkg::ST_RUN)
      else $error("Warning turned converter off");
endmodule : pfm_protect
`default_nettype wire

/* File: testbench/pfm_mgr_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Power manager and peer converters on the group lines
// ==========================================================
module pfm_mgr_model (
   input  wire logic       clk_sys,
   input  wire logic       grp_oe,
   input  wire logic       pg_oe,
   input  wire logic [3:0] peer_pull,
   input  wire logic       ext_pg_pull,
   input  wire logic       xprop_en,
   input  wire logic       err_mode,
   output logic            grp_in,
   output logic            pg_in,
   output logic            grp_fast
);
   logic [3:0] raw;
   logic       relay_q = 1'b0;
   logic       fast_q  = 1'b0;
   // wired group lines
   // Line 0 holds the block, lines 1..3 other groups, all pulled up
   assign raw = ~(peer_pull | {3'h0, grp_oe});
   assign pg_in = ~(pg_oe | ext_pg_pull);
   // manager relays a low line
   // Registered, so the relayed pull cannot hold itself up
   always_ff @(posedge clk_sys)
   begin
      relay_q <= xprop_en & ~(&raw);
      fast_q  <= err_mode & ~(&raw);
   end
   assign grp_in   = raw[0] & ~relay_q;
   assign grp_fast = fast_q;
endmodule : pfm_mgr_model
`default_nettype wire

/* File: testbench/pfm_protect_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pfm_protect_tb;
   // ==========================================================
   // Stimulus and observed signals
   // ==========================================================
   localparam int RC = 20;
   logic clk_sys = 1'b0, rst_n = 1'b0, on_cmd = 1'b0, ramp_done = 1'b0;
   logic above_prebias = 1'b1, ilim_active = 1'b0, tc = 1'b1;
   logic status_clr = 1'b0, ext_pg = 1'b0, xprop = 1'b0, err_mode = 1'b0;
   logic [7:0]  temp_c = 8'h19;
   logic [13:0] vout = 14'h03E8, vset = 14'h03E8, vramp = 14'h03E8, v;
   logic [3:0]  peer_pull = 4'h0;
   pfm_pkg::pfm_cfg_one_t   cfg1 = '0;
   pfm_pkg::pfm_cfg_two_t   cfg2 = '0;
   pfm_pkg::pfm_cfg_three_t cfg3 = '0;
   pfm_pkg::pfm_status_t    st;
   logic pg_out, pg_oe, grp_out, grp_oe, warn_report, tcomp_en, grp_fast;
   logic ramp_up, ramp_down, steady, fast_off, ls_on, pg_in, grp_in;
   int   seed = 81, fail_count = 0, num_checks = 0, k;
   // Fault table: status bit, then expected {fast_off, ls_on, ramp_down}
   int         bit_k [5] = '{0, 4, 3, 2, 4};
   logic [2:0] out_k [5] = '{3'h6, 3'h4, 3'h1, 3'h1, 3'h4};

   pfm_protect #(.RESTART_CYCLES(RC)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .on_cmd(on_cmd),
      .ramp_done(ramp_done), .above_prebias(above_prebias),
      .ilim_active(ilim_active), .temp_c(temp_c), .vout_mv(vout),
      .vset_mv(vset), .vramp_mv(vramp), .protection_config_one(cfg1),
      .protection_config_two(cfg2), .protection_config_three(cfg3),
      .current_limit_setpoint_tc(tc), .status_clr(status_clr),
      .pg_in(pg_in), .grp_in(grp_in), .grp_fast(grp_fast),
      .pg_out(pg_out), .pg_oe(pg_oe), .grp_out(grp_out), .grp_oe(grp_oe),
      .protection_status_reg(st), .warn_report(warn_report),
      .tcomp_en(tcomp_en), .ramp_up(ramp_up), .ramp_down(ramp_down),
      .steady(steady), .fast_off(fast_off), .ls_on(ls_on)
   );
   pfm_mgr_model mgr (
      .clk_sys(clk_sys), .grp_oe(grp_oe), .pg_oe(pg_oe),
      .peer_pull(peer_pull), .ext_pg_pull(ext_pg), .xprop_en(xprop),
      .err_mode(err_mode), .grp_in(grp_in), .pg_in(pg_in),
      .grp_fast(grp_fast)
   );

   // 50 MHz system clock
   always #10 clk_sys = ~clk_sys;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [13:0] pct(input logic [13:0] x, input int p);
      pct = 14'((int'(x) * p) / 100);
   endfunction : pct
   function automatic logic [6:0] st_exp(input int b);
      st_exp = 7'h7F;
      st_exp[b] = 1'b0;
   endfunction : st_exp
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Wait edges, then step past them so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : cyc
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   // Fresh setpoint each time so thresholds move around
   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      on_cmd <= 1'b0;
      ilim_active <= 1'b0;
      temp_c <= 8'h19;
      cfg1 <= '0;
      cfg2 <= {1'b0, 8'h78, 8'h55};
      cfg3 <= '0;
      peer_pull <= 4'h0;
      v = 14'h03E8 + 14'($random(seed) & 32'h0000_07FF);
      vset <= v;
      vout <= v;
      vramp <= v;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      cyc(1);
   endtask : do_reset
   task automatic up();
      @(posedge clk_sys);
      on_cmd <= 1'b1;
      cyc(3);
      chk({ramp_up, pg_oe}, 2'h3); // pin low while ramping
      @(posedge clk_sys);
      ramp_done <= 1'b1;
      @(posedge clk_sys);
      ramp_done <= 1'b0;
      cyc(3);
      chk({steady, pg_oe}, 2'h2); // in window
   endtask : up

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial
   begin
      do_reset();
      chk({st, pg_oe, grp_oe, tcomp_en}, {7'h7F, 3'h5}); // reset
      @(posedge clk_sys);
      tc <= 1'b0;
      cyc(2);
      chk(tcomp_en, 1'b0); // compensation off
      up();
      for (k = 0; k < 2; k++)
      begin
         @(posedge clk_sys);
         cfg3 <= {k[0], 1'b0};
         temp_c <= 8'h79 + 8'($random(seed) & 7);
         cyc(3);
         chk(st, st_exp(6)); // warning bit
         chk({warn_report, steady}, {k[0], 1'b1});
         @(posedge clk_sys);
         temp_c <= 8'h76;
         cyc(3);
         chk(st, st_exp(6)); // held in band
         @(posedge clk_sys);
         temp_c <= 8'h74;
         cyc(3);
         chk({st, warn_report}, {7'h7F, 1'b0}); // withdrawn
      end
      @(posedge clk_sys);
      vout <= pct(vset, 112);
      cyc(3);
      chk({pg_oe, pg_out, st, steady}, {2'h2, st_exp(5), 1'b1});
      // Corner between the two lower limits
      for (k = 0; k < 2; k++)
      begin
         @(posedge clk_sys);
         cfg2.pg_lo_95 <= k[0];
         vout <= pct(vset, 93);
         cyc(3);
         chk(pg_oe, k[0]); // low limit
      end
      @(posedge clk_sys);
      vout <= vset;
      ext_pg <= 1'b1;
      cyc(3);
      chk(st, st_exp(5)); // outside pull
      @(posedge clk_sys);
      ext_pg <= 1'b0;
      cyc(3);
      chk({pg_oe, st}, {1'b0, 7'h7F}); // released
      // Faults: overvoltage, overcurrent, undervoltage, temp, latched
      for (k = 0; k < 5; k++)
      begin
         do_reset();
         up();
         @(posedge clk_sys);
         cfg3 <= 2'h1;
         cfg1.latch_oc <= (k == 4);
         ilim_active <= (k == 1 || k == 4);
         case (k)
            0: vout <= pct(vset, 135);
            3: temp_c <= 8'h83;
            default: vout <= pct(vset, 80);
         endcase
         cyc(2);
         chk(st[bit_k[k]], 1'b0);
         chk({fast_off, ls_on, ramp_down}, out_k[k]);
         cyc(1);
         if (k != 0)
            chk({grp_oe, grp_out}, 2'h2); // group pulled
         // Cooling to exactly 120 C must not restart the converter
         if (k == 3)
         begin
            @(posedge clk_sys);
            ramp_done <= 1'b1;
            temp_c <= 8'h78;
            @(posedge clk_sys);
            ramp_done <= 1'b0;
            cyc(RC + 6);
            chk(ramp_up, 1'b0); // still at 120 C
            @(posedge clk_sys);
            temp_c <= 8'h77;
            cyc(3);
            chk(ramp_up, 1'b1); // restart
         end
         if (k == 1 || k == 4)
         begin
            @(posedge clk_sys);
            ilim_active <= 1'b0;
            vout <= vset;
            cyc(RC + 6);
            chk(ramp_up, k == 1); // retry
            if (k == 4)
            begin
               @(posedge clk_sys);
               status_clr <= 1'b1;
               @(posedge clk_sys);
               status_clr <= 1'b0;
               cyc(4);
               chk({ramp_up, st.overcurrent_flag}, 2'h3); // cleared
            end
         end
      end
      for (k = 0; k < 2; k++)
      begin
         do_reset();
         cfg1.trk_dis <= k[0];
         @(posedge clk_sys);
         on_cmd <= 1'b1;
         cyc(3);
         @(posedge clk_sys);
         // Below the ramp, so a low setpoint cannot also trip overvoltage
         vout <= vramp - 14'h00FB;
         cyc(2);
         chk({st.tracking_flag, fast_off}, k ? 2'h2 : 2'h1);
      end
      // Peer pulls its own line, manager relays it here
      for (k = 0; k < 2; k++)
      begin
         do_reset();
         up();
         @(posedge clk_sys);
         err_mode <= k[0];
         xprop <= 1'b1;
         peer_pull <= 4'h4;
         cyc(3);
         chk({ramp_down, fast_off}, k ? 2'h1 : 2'h2);
      end
      test_done();
   end

   // Run needs about 350 cycles; cut off at about thirty times that
   initial
   begin
      #200us;
      fail_count++;
      test_done();
   end
endmodule : pfm_protect_tb
`default_nettype wire
